// file: logic/wdt_sys_timers.sv
// Watchdog and three system timers with APB register access
`timescale 1ns/1ps
`default_nettype none
module wdt_sys_timers #(
	parameter int WD_WIDTH = 24,
	parameter int TMR_WIDTH = 16,
	parameter int TICK_DIV = wdt_sys_timers_pkg::TICK_DIV
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Events out
	output logic irq_o,
	output logic card_rst_o
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (WD_WIDTH < 2 || WD_WIDTH > $bits(wdt_sys_timers_pkg::WD_PRESET_RST)) begin : g_wd_chk
		$error("WD_WIDTH out of range");
	end
	if (TMR_WIDTH < 2 || TMR_WIDTH > $bits(wdt_sys_timers_pkg::TMR_PRESET_RST)) begin : g_tmr_chk
		$error("TMR_WIDTH out of range");
	end
	if (TICK_DIV < 2 || TICK_DIV > 65536) begin : g_div_chk
		$error("TICK_DIV out of range");
	end

	localparam int NB = wdt_sys_timers_pkg::IRQ_BITS;

	// ****************************************
	// Declarations
	// ****************************************
	logic [15:0] div_q;
	logic tick_q;
	logic wd_en_q;
	logic wd_rstmode_q;
	logic wd_log_q;
	logic wd_reload_q;
	logic [WD_WIDTH-1:0] wd_preset_q;
	logic [WD_WIDTH-1:0] wd_cnt_q;
	logic wd_tc;
	logic cascade_q;
	logic [2:0] tmr_en_q;
	logic [2:0] tmr_reload_q;
	logic [TMR_WIDTH-1:0] tmr_preset_q [3];
	logic [TMR_WIDTH-1:0] tmr_cnt_q [3];
	logic [2:0] tmr_tc;
	logic [2:0] tmr_step;
	logic [NB-1:0] irq_stat_q;
	logic [NB-1:0] irq_mask_q;
	logic [NB-1:0] irq_ev;
	logic [7:0] rst_cnt_q;
	logic wr_acc;
	logic rd_acc;
	logic addr_ok;
	logic [31:0] rd_mux;

	// ****************************************
	// APB decode (zero wait state)
	// ****************************************
	assign wr_acc = psel_i & penable_i & pwrite_i;
	assign rd_acc = psel_i & penable_i & ~pwrite_i;

	// Address check and read mux
	always_comb begin
		addr_ok = 1'b1;
		rd_mux = 32'h0;
		unique case (paddr_i)
			wdt_sys_timers_pkg::WD_CTRL_OFF: begin
				rd_mux = {29'h0, wd_log_q, wd_rstmode_q, wd_en_q};
			end
			wdt_sys_timers_pkg::WD_PRESET_OFF: rd_mux = 32'(wd_preset_q);
			wdt_sys_timers_pkg::WD_COUNT_OFF: rd_mux = 32'(wd_cnt_q);
			wdt_sys_timers_pkg::TMR_CTRL_OFF: rd_mux = {28'h0, cascade_q, tmr_en_q};
			wdt_sys_timers_pkg::TMR1_PRESET_OFF: rd_mux = 32'(tmr_preset_q[0]);
			wdt_sys_timers_pkg::TMR2_PRESET_OFF: rd_mux = 32'(tmr_preset_q[1]);
			wdt_sys_timers_pkg::TMR3_PRESET_OFF: rd_mux = 32'(tmr_preset_q[2]);
			wdt_sys_timers_pkg::TMR1_COUNT_OFF: rd_mux = 32'(tmr_cnt_q[0]);
			wdt_sys_timers_pkg::TMR2_COUNT_OFF: rd_mux = 32'(tmr_cnt_q[1]);
			wdt_sys_timers_pkg::TMR3_COUNT_OFF: rd_mux = 32'(tmr_cnt_q[2]);
			wdt_sys_timers_pkg::IRQ_STATUS_OFF: rd_mux = 32'(irq_stat_q);
			wdt_sys_timers_pkg::IRQ_MASK_OFF: rd_mux = 32'(irq_mask_q);
			default: addr_ok = 1'b0;
		endcase
	end

	// Bus answer registers
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prdata_o <= 32'h0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i & ~penable_i;
			pslverr_o <= psel_i & ~penable_i & ~addr_ok;
			prdata_o <= (psel_i & ~penable_i & ~pwrite_i) ? rd_mux : 32'h0;
		end
	end

	// ****************************************
	// 1 MHz tick divider
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i | card_rst_o) begin
			div_q <= 16'h0;
			tick_q <= 1'b0;
		end else if (div_q == 16'(TICK_DIV - 1)) begin
			div_q <= 16'h0;
			tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 16'h1;
			tick_q <= 1'b0;
		end
	end

	// ****************************************
	// Watchdog control
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i | card_rst_o) begin
			wd_en_q <= 1'b0;
			wd_rstmode_q <= 1'b0;
			wd_preset_q <= wdt_sys_timers_pkg::WD_PRESET_RST[WD_WIDTH-1:0];
			wd_reload_q <= 1'b1;
		end else begin
			wd_reload_q <= 1'b0;
			if (wr_acc && paddr_i == wdt_sys_timers_pkg::WD_CTRL_OFF && !wd_rstmode_q) begin
				wd_en_q <= pwdata_i[wdt_sys_timers_pkg::WD_CTRL_EN_BIT];
				wd_rstmode_q <= pwdata_i[wdt_sys_timers_pkg::WD_CTRL_RSTMODE_BIT] &
					pwdata_i[wdt_sys_timers_pkg::WD_CTRL_EN_BIT];
				wd_reload_q <= 1'b1;
			end
			if (wr_acc && paddr_i == wdt_sys_timers_pkg::WD_PRESET_OFF) begin
				wd_preset_q <= pwdata_i[WD_WIDTH-1:0];
				wd_reload_q <= 1'b1;
			end
		end
	end

	// Watchdog counter
	assign wd_tc = wd_en_q & tick_q & (wd_cnt_q == '0);
	always_ff @(posedge clk_i) begin
		if (sys_rst_i | card_rst_o) begin
			wd_cnt_q <= wdt_sys_timers_pkg::WD_PRESET_RST[WD_WIDTH-1:0];
		end else if (wd_reload_q || wd_tc) begin
			wd_cnt_q <= wd_preset_q;
		end else if (wd_en_q && tick_q) begin
			wd_cnt_q <= wd_cnt_q - 1'b1;
		end
	end

	// Card reset stretcher and log flag
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rst_cnt_q <= 8'h0;
			card_rst_o <= 1'b0;
		end else if (wd_tc && wd_rstmode_q) begin
			rst_cnt_q <= 8'(wdt_sys_timers_pkg::CARD_RST_CYCLES - 1);
			card_rst_o <= 1'b1;
		end else if (rst_cnt_q != 8'h0) begin
			rst_cnt_q <= rst_cnt_q - 8'h1;
		end else begin
			card_rst_o <= 1'b0;
		end
	end

	// Log bit survives card reset, cleared by writing one
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wd_log_q <= 1'b0;
		end else if (wd_tc && wd_rstmode_q) begin
			wd_log_q <= 1'b1;
		end else if (wr_acc && paddr_i == wdt_sys_timers_pkg::WD_CTRL_OFF &&
			pwdata_i[wdt_sys_timers_pkg::WD_CTRL_LOG_BIT]) begin
			wd_log_q <= 1'b0;
		end
	end

	// ****************************************
	// System timers control
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i | card_rst_o) begin
			tmr_en_q <= 3'h0;
			cascade_q <= 1'b0;
			tmr_reload_q <= 3'h7;
			for (int i = 0; i < 3; i++) begin
				tmr_preset_q[i] <= wdt_sys_timers_pkg::TMR_PRESET_RST[TMR_WIDTH-1:0];
			end
		end else begin
			tmr_reload_q <= 3'h0;
			if (wr_acc && paddr_i == wdt_sys_timers_pkg::TMR_CTRL_OFF) begin
				tmr_en_q <= pwdata_i[2:0];
				cascade_q <= pwdata_i[wdt_sys_timers_pkg::TMR_CTRL_CASCADE_BIT];
				tmr_reload_q <= pwdata_i[2:0] & ~tmr_en_q;
			end
			for (int i = 0; i < 3; i++) begin
				if (wr_acc && paddr_i == 8'(wdt_sys_timers_pkg::TMR1_PRESET_OFF + 8'(4 * i))) begin
					tmr_preset_q[i] <= pwdata_i[TMR_WIDTH-1:0];
					tmr_reload_q[i] <= 1'b1;
				end
			end
		end
	end

	// Step enables: timer 2 counts timer 1 terminals in cascade
	always_comb begin
		tmr_step[0] = tmr_en_q[0] & tick_q;
		tmr_tc[0] = tmr_step[0] & (tmr_cnt_q[0] == '0); // Settled before timer two reads it
		tmr_step[1] = tmr_en_q[1] & (cascade_q ? tmr_tc[0] : tick_q);
		tmr_tc[1] = tmr_step[1] & (tmr_cnt_q[1] == '0);
		tmr_step[2] = tmr_en_q[2] & tick_q;
		tmr_tc[2] = tmr_step[2] & (tmr_cnt_q[2] == '0);
	end

	// Timer counters, reload on terminal count
	always_ff @(posedge clk_i) begin
		if (sys_rst_i | card_rst_o) begin
			for (int i = 0; i < 3; i++) begin
				tmr_cnt_q[i] <= wdt_sys_timers_pkg::TMR_PRESET_RST[TMR_WIDTH-1:0];
			end
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (tmr_reload_q[i] || tmr_tc[i]) begin
					tmr_cnt_q[i] <= tmr_preset_q[i];
				end else if (tmr_step[i]) begin
					tmr_cnt_q[i] <= tmr_cnt_q[i] - 1'b1;
				end
			end
		end
	end

	// ****************************************
	// Interrupt status, mask, output
	// ****************************************
	assign irq_ev = {tmr_tc[2], tmr_tc[1], tmr_tc[0], wd_tc & ~wd_rstmode_q};

	// Sticky status, read clears only reported bits, new event wins
	always_ff @(posedge clk_i) begin
		if (sys_rst_i | card_rst_o) begin
			irq_stat_q <= '0;
		end else if (rd_acc && paddr_i == wdt_sys_timers_pkg::IRQ_STATUS_OFF) begin
			irq_stat_q <= (irq_stat_q & ~prdata_o[NB-1:0]) | irq_ev; // Setup-cycle events kept
		end else begin
			irq_stat_q <= irq_stat_q | irq_ev;
		end
	end

	// Mask register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i | card_rst_o) begin
			irq_mask_q <= wdt_sys_timers_pkg::IRQ_MASK_RST;
		end else if (wr_acc && paddr_i == wdt_sys_timers_pkg::IRQ_MASK_OFF) begin
			irq_mask_q <= pwdata_i[NB-1:0];
		end
	end

	// Interrupt output register
	always_ff @(posedge clk_i) begin
		if (sys_rst_i | card_rst_o) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |((irq_stat_q | irq_ev) & irq_mask_q);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_wd_dec;
		@(posedge clk_i) disable iff (sys_rst_i | card_rst_o)
		(wd_en_q && tick_q && !wd_reload_q && !wd_tc) |=> (wd_cnt_q == $past(wd_cnt_q) - 1'b1);
	endproperty
	a_wd_dec: assert property (p_wd_dec) else $error("watchdog did not decrement");

	property p_wd_preset;
		@(posedge clk_i) disable iff (sys_rst_i | card_rst_o)
		(wr_acc && paddr_i == wdt_sys_timers_pkg::WD_PRESET_OFF) |=> ##1
		(wd_cnt_q == $past(pwdata_i[WD_WIDTH-1:0], 2));
	endproperty
	a_wd_preset: assert property (p_wd_preset) else $error("preset not loaded");

	property p_wd_irq;
		@(posedge clk_i) disable iff (sys_rst_i | card_rst_o)
		(wd_tc && !wd_rstmode_q) |=> irq_stat_q[wdt_sys_timers_pkg::IRQ_WD_BIT];
	endproperty
	a_wd_irq: assert property (p_wd_irq) else $error("watchdog irq missing");

	property p_wd_lock;
		@(posedge clk_i) disable iff (sys_rst_i | card_rst_o)
		wd_rstmode_q |=> (wd_rstmode_q && wd_en_q);
	endproperty
	a_wd_lock: assert property (p_wd_lock) else $error("locked watchdog disabled");

	property p_wd_log;
		@(posedge clk_i) disable iff (sys_rst_i)
		(wd_tc && wd_rstmode_q) |=> (card_rst_o && wd_log_q) [*8];
	endproperty
	a_wd_log: assert property (p_wd_log) else $error("reset or log missing");

	property p_wd_rst;
		@(posedge clk_i) disable iff (sys_rst_i)
		$rose(card_rst_o) |-> $past(wd_tc && wd_rstmode_q);
	endproperty
	a_wd_rst: assert property (p_wd_rst) else $error("card reset without expiry");

	property p_tmr_tc;
		@(posedge clk_i) disable iff (sys_rst_i | card_rst_o)
		tmr_tc[2] |=> (irq_stat_q[wdt_sys_timers_pkg::IRQ_TMR3_BIT] && tmr_cnt_q[2] == $past(tmr_preset_q[2]));
	endproperty
	a_tmr_tc: assert property (p_tmr_tc) else $error("timer terminal mishandled");

	property p_cascade;
		@(posedge clk_i) disable iff (sys_rst_i | card_rst_o)
		(cascade_q && tmr_en_q[1] && !tmr_tc[0] && !tmr_reload_q[1]) |=> $stable(tmr_cnt_q[1]);
	endproperty
	a_cascade: assert property (p_cascade) else $error("cascaded timer moved");

	property p_tmr1_irq;
		@(posedge clk_i) disable iff (sys_rst_i | card_rst_o)
		tmr_tc[0] |=> irq_stat_q[wdt_sys_timers_pkg::IRQ_TMR1_BIT];
	endproperty
	a_tmr1_irq: assert property (p_tmr1_irq) else $error("timer one irq missing");

	property p_cascade_dec;
		@(posedge clk_i) disable iff (sys_rst_i | card_rst_o)
		(cascade_q && tmr_en_q[1] && tmr_tc[0] && !tmr_tc[1] && !tmr_reload_q[1]) |=>
		(tmr_cnt_q[1] == $past(tmr_cnt_q[1]) - 1'b1);
	endproperty
	a_cascade_dec: assert property (p_cascade_dec) else $error("cascade step missed");

	c_wd_reset: cover property (@(posedge clk_i) $rose(card_rst_o));
	c_wd_irq: cover property (@(posedge clk_i) irq_o && irq_stat_q[0]);
	c_cascade: cover property (@(posedge clk_i) cascade_q && tmr_tc[1]);

endmodule // wdt_sys_timers
`default_nettype wire

// file: logic/wdt_sys_timers_pkg.sv
// Package of register map, field positions and timing constants for the watchdog and system timers
`default_nettype none
package wdt_sys_timers_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] WD_CTRL_OFF = 8'h00;
	localparam logic [7:0] WD_PRESET_OFF = 8'h04;
	localparam logic [7:0] WD_COUNT_OFF = 8'h08;
	localparam logic [7:0] TMR_CTRL_OFF = 8'h0c;
	localparam logic [7:0] TMR1_PRESET_OFF = 8'h10;
	localparam logic [7:0] TMR2_PRESET_OFF = 8'h14;
	localparam logic [7:0] TMR3_PRESET_OFF = 8'h18;
	localparam logic [7:0] TMR1_COUNT_OFF = 8'h1c;
	localparam logic [7:0] TMR2_COUNT_OFF = 8'h20;
	localparam logic [7:0] TMR3_COUNT_OFF = 8'h24;
	localparam logic [7:0] IRQ_STATUS_OFF = 8'h28;
	localparam logic [7:0] IRQ_MASK_OFF = 8'h2c;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int WD_CTRL_EN_BIT = 0;
	localparam int WD_CTRL_RSTMODE_BIT = 1;
	localparam int WD_CTRL_LOG_BIT = 2;
	localparam int TMR_CTRL_CASCADE_BIT = 3;
	localparam int IRQ_WD_BIT = 0;
	localparam int IRQ_TMR1_BIT = 1;
	localparam int IRQ_TMR2_BIT = 2;
	localparam int IRQ_TMR3_BIT = 3;
	localparam int IRQ_BITS = 4;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [23:0] WD_PRESET_RST = 24'hffffff;
	localparam logic [15:0] TMR_PRESET_RST = 16'hffff;
	localparam logic [IRQ_BITS-1:0] IRQ_MASK_RST = 4'h0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_FREQ_HZ = 250_000_000;
	localparam int TICK_FREQ_HZ = 1_000_000;
	localparam int TICK_DIV = CLK_FREQ_HZ / TICK_FREQ_HZ;
	localparam int CARD_RST_CYCLES = 16;

endpackage
`default_nettype wire

// file: verification/wdt_sys_timers_tb.sv
// Self-checking testbench for the watchdog and system timers
`timescale 1ns/1ps
`default_nettype none
module wdt_sys_timers_tb;

	// ****************************************
	// Signals and bench state
	// ****************************************
	localparam int DIV = 4;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, irq_o, card_rst_o;
	logic [32:0] exp_q[$];
	logic [32:0] note;
	logic [15:0] lfsr = 16'h59fc;
	logic [23:0] rnd;
	int errors = 0;
	int check_count = 0;

	// Clock at 250 MHz
	always #2 clk_i = ~clk_i;

	wdt_sys_timers #(.WD_WIDTH(24), .TMR_WIDTH(16), .TICK_DIV(DIV)) u_dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o), .card_rst_o(card_rst_o)
	);

	// ****************************************
	// Helpers
	// ****************************************
	// Galois step of the stimulus generator
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer, entered and left on a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50) errors++;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
		exp_q.push_back({err, exp});
		apb(1'b0, a, 32'h0);
	endtask

	// Bounded wait for irq_o or card_rst_o to reach a level
	task automatic wait_lvl(input logic use_rst, input logic lvl);
		int n;
		n = 0;
		while ((use_rst ? card_rst_o : irq_o) !== lvl && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		cmp({31'h0, n < 3000}, 32'h1);
	endtask

	// Read monitor pops the oldest note on each completed read
	always @(posedge clk_i) begin
		if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
			note = exp_q.pop_front();
			cmp(prdata_o, note[31:0]);
			cmp({31'h0, pslverr_o}, {31'h0, note[32]});
		end
	end

	task automatic conclude;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Hang guard well beyond the expected run
	initial begin
		repeat (60000) @(posedge clk_i);
		errors++;
		conclude();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		// Reset values and an unmapped place
		rd(wdt_sys_timers_pkg::WD_PRESET_OFF, 32'h00ffffff, 1'b0);
		rd(wdt_sys_timers_pkg::TMR2_PRESET_OFF, 32'h0000ffff, 1'b0);
		rd(wdt_sys_timers_pkg::IRQ_MASK_OFF, 32'h0, 1'b0);
		apb(1'b1, 8'h3c, 32'hffffffff);
		rd(8'h30, 32'h0, 1'b1);
		// Random 24-bit watchdog preset readback
		lfsr = lfsr_next(lfsr);
		rnd[15:0] = lfsr;
		lfsr = lfsr_next(lfsr);
		rnd[23:16] = lfsr[7:0];
		apb(1'b1, wdt_sys_timers_pkg::WD_PRESET_OFF, {8'hff, rnd});
		rd(wdt_sys_timers_pkg::WD_PRESET_OFF, {8'h00, rnd}, 1'b0);
		rd(wdt_sys_timers_pkg::WD_COUNT_OFF, {8'h00, rnd}, 1'b0);
		// Timers one and three free running, both unmasked
		apb(1'b1, wdt_sys_timers_pkg::TMR1_PRESET_OFF, 32'h3);
		rd(wdt_sys_timers_pkg::TMR1_COUNT_OFF, 32'h3, 1'b0);
		apb(1'b1, wdt_sys_timers_pkg::TMR3_PRESET_OFF, 32'h5);
		apb(1'b1, wdt_sys_timers_pkg::IRQ_MASK_OFF, 32'ha);
		apb(1'b1, wdt_sys_timers_pkg::TMR_CTRL_OFF, 32'h5);
		wait_lvl(1'b0, 1'b1);
		repeat ((5 + 1) * DIV * 2) @(posedge clk_i);
		apb(1'b1, wdt_sys_timers_pkg::TMR_CTRL_OFF, 32'h0);
		rd(wdt_sys_timers_pkg::IRQ_STATUS_OFF, 32'ha, 1'b0);
		rd(wdt_sys_timers_pkg::IRQ_STATUS_OFF, 32'h0, 1'b0);
		cmp({31'h0, irq_o}, 32'h0);
		// Cascade: timer two counts timer one terminals
		apb(1'b1, wdt_sys_timers_pkg::TMR1_PRESET_OFF, 32'h1);
		apb(1'b1, wdt_sys_timers_pkg::TMR2_PRESET_OFF, 32'h1);
		apb(1'b1, wdt_sys_timers_pkg::IRQ_MASK_OFF, 32'h4);
		apb(1'b1, wdt_sys_timers_pkg::TMR_CTRL_OFF, 32'hb);
		wait_lvl(1'b0, 1'b1);
		apb(1'b1, wdt_sys_timers_pkg::TMR_CTRL_OFF, 32'h0);
		rd(wdt_sys_timers_pkg::IRQ_STATUS_OFF, 32'h6, 1'b0);
		// Watchdog in interrupt mode
		apb(1'b1, wdt_sys_timers_pkg::IRQ_MASK_OFF, 32'h1);
		apb(1'b1, wdt_sys_timers_pkg::WD_PRESET_OFF, 32'h2);
		apb(1'b1, wdt_sys_timers_pkg::WD_CTRL_OFF, 32'h1);
		wait_lvl(1'b0, 1'b1);
		apb(1'b1, wdt_sys_timers_pkg::WD_CTRL_OFF, 32'h0);
		rd(wdt_sys_timers_pkg::IRQ_STATUS_OFF, 32'h1, 1'b0);
		// Watchdog in reset mode, serviced once, disable refused
		apb(1'b1, wdt_sys_timers_pkg::WD_PRESET_OFF, 32'h5);
		apb(1'b1, wdt_sys_timers_pkg::WD_CTRL_OFF, 32'h3);
		apb(1'b1, wdt_sys_timers_pkg::WD_CTRL_OFF, 32'h0);
		rd(wdt_sys_timers_pkg::WD_CTRL_OFF, 32'h3, 1'b0);
		apb(1'b1, wdt_sys_timers_pkg::WD_PRESET_OFF, 32'h5);
		wait_lvl(1'b1, 1'b1);
		cmp({31'h0, irq_o}, 32'h0);
		wait_lvl(1'b1, 1'b0);
		@(posedge clk_i);
		rd(wdt_sys_timers_pkg::WD_CTRL_OFF, 32'h4, 1'b0);
		rd(wdt_sys_timers_pkg::IRQ_MASK_OFF, 32'h0, 1'b0);
		rd(wdt_sys_timers_pkg::WD_PRESET_OFF, 32'h00ffffff, 1'b0);
		rd(wdt_sys_timers_pkg::WD_COUNT_OFF, 32'h00ffffff, 1'b0);
		apb(1'b1, wdt_sys_timers_pkg::WD_CTRL_OFF, 32'h4);
		rd(wdt_sys_timers_pkg::WD_CTRL_OFF, 32'h0, 1'b0);
		repeat (2) @(posedge clk_i);
		conclude();
	end

endmodule // wdt_sys_timers_tb
`default_nettype wire
